/* File: logic/rmw_params.svh */
/*
 receive mode and frame-wait timeout block: offsets, fields, reset values.
 assumes inclusion by bare name from the design files.
*/
`ifndef RMW_PARAMS_SVH
`define RMW_PARAMS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define RMW_ADDR_SYS_CFG 12'h004
`define RMW_ADDR_WAIT_PERIOD 12'h00C
`define RMW_ADDR_CTRL 12'h034
`define RMW_ADDR_STATUS 12'h03C
`define RMW_ADDR_MASK 12'h040
// ----------------------------------------
// field positions
// ----------------------------------------
`define RMW_BIT_LOW_RATE 22
`define RMW_BIT_WAIT_TO_EN 28
`define RMW_BIT_AUTO_REEN 29
`define RMW_BIT_RX_ENABLE 0
`define RMW_BIT_RX_DISABLE 1
`define RMW_BIT_FRAME_OK 0
`define RMW_BIT_WAIT_TO 1
`define RMW_BIT_RX_ERROR 2
`define RMW_RSVD_MASK 32'h0FB80000
`define RMW_SYS_CFG_RESET 32'h00000000
`define RMW_WAIT_PERIOD_RESET 16'h0000
`define RMW_EVENT_BITS 3
`endif

/* File: logic/rmw_pkg.sv */
/*
 types of the receive mode and frame-wait timeout block.
 assumes no other package.
*/
package rmw_pkg;
   typedef enum logic [2:0] {
      RMW_IDLE = 3'b001,
      RMW_LISTEN = 3'b010,
      RMW_TIMED = 3'b100
   } rmw_state_type;
endpackage

/* File: logic/rmw_downcount.sv */
/*
 frame-wait down-counter: loads on start, counts to zero, pulses expiry.
 assumes start, stop and period on the same clock as the counter.
*/
`timescale 1ns/1ps
module rmw_downcount #(
   parameter int WIDTH = 16
) (
   input wire logic clk, // core clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic start, // load and run
   input wire logic stop, // abandon the count
   input wire logic [WIDTH-1:0] period, // load value
   output logic running, // count in progress
   output logic expired // one-cycle expiry pulse
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic run_q;
   logic run_d;
   logic exp_q;
   logic exp_d;

   // next count, stop wins over expiry
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (start) begin
         cnt_d = period;
         run_d = 1'b1;
      end else if (stop) begin
         run_d = 1'b0;
      end else if (run_q) begin
         if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
            run_d = 1'b0;
            exp_d = 1'b1;
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // register the count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign running = run_q;
   assign expired = exp_q;
endmodule

/* File: logic/rmw_top.sv */
/*
 receive mode configuration and frame-wait timeout, APB register slave.
 assumes frame and error event pins are asynchronous to CORE_CLK.
*/
// Functional notes
// (RULE_01) host writes zero to reserved bits
// (RULE_02) low-rate bit selects long delimiter, 110k
// (RULE_03) clear bit: short delimiter, rate from header
// (RULE_04) timeout enable arms down-count per receive enable
// (RULE_05) expiry before valid frame turns receiver off
// (RULE_06) count period from timeout-period register
// (RULE_07) expiry sets wait-timeout event flag
// (RULE_08) without auto re-enable receiver idles after events
// (RULE_09) valid frame or disable stops count silently
`timescale 1ns/1ps
`include "rmw_params.svh"
module rmw_top #(
   parameter int PERIOD_WIDTH = 16
) (
   input wire logic CORE_CLK, // 200 MHz core clock
   input wire logic RESET_N, // async reset, active low
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb access phase
   input wire logic PWRITE, // apb direction
   input wire logic [11:0] PADDR, // apb byte address
   input wire logic [31:0] PWDATA, // apb write data
   output logic [31:0] PRDATA, // apb read data
   output logic PREADY, // apb ready
   output logic PSLVERR, // apb error
   input wire logic FRAME_OK, // valid frame received, pin
   input wire logic RX_ERROR, // reception failure, pin
   output logic RX_ON, // receiver enabled
   output logic LONG_SFD, // search long delimiter
   output logic RATE_FROM_HEADER, // payload rate from header
   output logic IRQ // level interrupt
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [1:0] ok_sync_q, err_sync_q;
   logic ok_prev_q, err_prev_q;
   logic ok_evt, err_evt;
   logic [31:0] cfg_q, cfg_d;
   logic [PERIOD_WIDTH-1:0] per_q, per_d;
   logic [`RMW_EVENT_BITS-1:0] sts_q, sts_d, msk_q, msk_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q, ready_d, err_q, err_d;
   logic irq_q, irq_d;
   logic long_q, rate_q, rx_on_q;
   rmw_pkg::rmw_state_type st_q, st_d;
   logic setup, wr, rd, hit;
   logic en_cmd, dis_cmd, cnt_start, cnt_stop, cnt_exp;
   logic [`RMW_EVENT_BITS-1:0] evt;

   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // two stages, then edge detect on the second
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ok_sync_q <= 2'h0;
         err_sync_q <= 2'h0;
         ok_prev_q <= 1'b0;
         err_prev_q <= 1'b0;
      end else begin
         ok_sync_q <= {ok_sync_q[0], FRAME_OK};
         err_sync_q <= {err_sync_q[0], RX_ERROR};
         ok_prev_q <= ok_sync_q[1];
         err_prev_q <= err_sync_q[1];
      end
   end
   assign ok_evt = ok_sync_q[1] & ~ok_prev_q;
   assign err_evt = err_sync_q[1] & ~err_prev_q;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // no wait state: answer in the access phase's first cycle is registered
   assign setup = PSEL & ~PENABLE;
   assign wr = setup & PWRITE;
   assign rd = setup & ~PWRITE;
   assign hit = (PADDR == `RMW_ADDR_SYS_CFG) || (PADDR == `RMW_ADDR_WAIT_PERIOD) ||
                (PADDR == `RMW_ADDR_CTRL) || (PADDR == `RMW_ADDR_STATUS) ||
                (PADDR == `RMW_ADDR_MASK);
   assign en_cmd = wr && (PADDR == `RMW_ADDR_CTRL) && PWDATA[`RMW_BIT_RX_ENABLE];
   assign dis_cmd = wr && (PADDR == `RMW_ADDR_CTRL) && PWDATA[`RMW_BIT_RX_DISABLE];

   // register writes, read mux, events
   always_comb begin
      cfg_d = cfg_q;
      per_d = per_q;
      msk_d = msk_q;
      rdata_d = 32'h00000000;
      ready_d = setup;
      err_d = setup & ~hit;
      evt = '0;
      evt[`RMW_BIT_FRAME_OK] = ok_evt & (st_q != rmw_pkg::RMW_IDLE);
      evt[`RMW_BIT_WAIT_TO] = cnt_exp; // [RULE_07]
      evt[`RMW_BIT_RX_ERROR] = err_evt & (st_q != rmw_pkg::RMW_IDLE);
      sts_d = sts_q;
      if (wr && PADDR == `RMW_ADDR_SYS_CFG) begin
         cfg_d = PWDATA & ~`RMW_RSVD_MASK; // [RULE_01]
      end
      if (wr && PADDR == `RMW_ADDR_WAIT_PERIOD) begin
         per_d = PWDATA[PERIOD_WIDTH-1:0];
      end
      if (wr && PADDR == `RMW_ADDR_MASK) begin
         msk_d = PWDATA[`RMW_EVENT_BITS-1:0];
      end
      if (wr && PADDR == `RMW_ADDR_STATUS) begin
         sts_d = sts_d & ~PWDATA[`RMW_EVENT_BITS-1:0];
      end
      sts_d = sts_d | evt; // set wins over clear
      if (rd) begin
         case (PADDR)
            `RMW_ADDR_SYS_CFG: rdata_d = cfg_q;
            `RMW_ADDR_WAIT_PERIOD: rdata_d = {{(32-PERIOD_WIDTH){1'b0}}, per_q};
            `RMW_ADDR_CTRL: rdata_d = {31'h00000000, st_q != rmw_pkg::RMW_IDLE};
            `RMW_ADDR_STATUS: rdata_d = {{(32-`RMW_EVENT_BITS){1'b0}}, sts_q};
            `RMW_ADDR_MASK: rdata_d = {{(32-`RMW_EVENT_BITS){1'b0}}, msk_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      irq_d = |(sts_d & msk_d);
   end

   // register file flops
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= `RMW_SYS_CFG_RESET;
         per_q <= `RMW_WAIT_PERIOD_RESET;
         sts_q <= '0;
         msk_q <= '0;
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         per_q <= per_d;
         sts_q <= sts_d;
         msk_q <= msk_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
         irq_q <= irq_d;
      end
   end

   // ----------------------------------------
   // receiver state
   // ----------------------------------------
   // enable, events, auto re-enable
   always_comb begin
      st_d = st_q;
      cnt_start = 1'b0;
      cnt_stop = 1'b0;
      case (st_q)
         rmw_pkg::RMW_IDLE: begin
            if (en_cmd && !dis_cmd) begin
               if (cfg_q[`RMW_BIT_WAIT_TO_EN]) begin
                  st_d = rmw_pkg::RMW_TIMED;
                  cnt_start = 1'b1; // [RULE_04] [RULE_06]
               end else begin
                  st_d = rmw_pkg::RMW_LISTEN;
               end
            end
         end
         rmw_pkg::RMW_LISTEN, rmw_pkg::RMW_TIMED: begin
            if (dis_cmd) begin
               st_d = rmw_pkg::RMW_IDLE;
               cnt_stop = 1'b1; // [RULE_09]
            end else if (cnt_exp) begin
               st_d = rmw_pkg::RMW_IDLE; // [RULE_05]
            end else if (ok_evt || err_evt) begin
               cnt_stop = 1'b1; // [RULE_09]
               if (!cfg_q[`RMW_BIT_AUTO_REEN] || ok_evt) begin
                  st_d = rmw_pkg::RMW_IDLE; // [RULE_08]
               end else begin
                  st_d = rmw_pkg::RMW_LISTEN;
               end
            end else if (en_cmd && cfg_q[`RMW_BIT_WAIT_TO_EN]) begin
               st_d = rmw_pkg::RMW_TIMED;
               cnt_start = 1'b1; // [RULE_04]
            end
         end
         default: st_d = rmw_pkg::RMW_IDLE;
      endcase
   end

   // state and mode output flops
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= rmw_pkg::RMW_IDLE;
         rx_on_q <= 1'b0;
         long_q <= 1'b0;
         rate_q <= 1'b1;
      end else begin
         st_q <= st_d;
         rx_on_q <= st_d != rmw_pkg::RMW_IDLE; // pin copy of the state, straight from a flop
         long_q <= cfg_d[`RMW_BIT_LOW_RATE]; // [RULE_02]
         rate_q <= ~cfg_d[`RMW_BIT_LOW_RATE]; // [RULE_03]
      end
   end

   // frame-wait down-count
   rmw_downcount #(
      .WIDTH(PERIOD_WIDTH)
   ) u_downcount (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .start(cnt_start),
      .stop(cnt_stop),
      .period(per_q),
      .running(),
      .expired(cnt_exp)
   );

   assign PRDATA = rdata_q;
   assign PREADY = ready_q;
   assign PSLVERR = err_q;
   assign RX_ON = rx_on_q;
   assign LONG_SFD = long_q;
   assign RATE_FROM_HEADER = rate_q;
   assign IRQ = irq_q;
endmodule

/* File: test/rmw_top_asserts.sv */
/* port checker for the receive mode and wait timeout block.
 assumes binding onto rmw_top, apb setup at a rising edge. */
`timescale 1ns/1ps
module rmw_top_asserts (
   input wire logic CORE_CLK, // clock
   input wire logic RESET_N, // reset, active low
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb access
   input wire logic PWRITE, // apb direction
   input wire logic [11:0] PADDR, // apb address
   input wire logic [31:0] PWDATA, // apb write data
   input wire logic [31:0] PRDATA, // apb read data
   input wire logic PREADY, // apb ready
   input wire logic PSLVERR, // apb error
   input wire logic FRAME_OK, // frame pin
   input wire logic RX_ERROR, // error pin
   input wire logic RX_ON, // receiver on
   input wire logic LONG_SFD, // long delimiter
   input wire logic RATE_FROM_HEADER, // rate from header
   input wire logic IRQ // interrupt
);
   // ----------------------------------------
   // helper terms
   // ----------------------------------------
   wire setup = PSEL && !PENABLE;
   wire ctl_wr = setup && PWRITE && PADDR == 12'h034;
   wire en_wr = ctl_wr && PWDATA[0];
   wire off_wr = ctl_wr && PWDATA[1] && !PWDATA[0];
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // bus timing and register properties
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
   a_setup_answer: assert property (setup |=> PREADY) else $error("no ready after setup");
   a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   a_err_zero: assert property (PSLVERR |-> PRDATA == 32'h00000000) else $error("refused read not zero");
   a_rsvd_zero: assert property (PREADY && !PWRITE && PADDR == 12'h004 |->
      (PRDATA & 32'h0FB80000) == 32'h00000000) else $error("reserved bits read nonzero");
   a_rate_pair: assert property (LONG_SFD != RATE_FROM_HEADER) else $error("mode outputs agree");
   a_on_cause: assert property ($rose(RX_ON) |-> $past(en_wr) || $past(en_wr, 2))
      else $error("receiver on without command");
   a_enable_on: assert property (en_wr && !PWDATA[1] |-> ##[1:2] RX_ON) else $error("enable ignored");
   a_disable_off: assert property (off_wr |-> ##[1:2] !RX_ON) else $error("disable ignored");
   a_irq_clear: assert property ($fell(IRQ) |->
      $past(setup && PWRITE && (PADDR == 12'h03C || PADDR == 12'h040))) else $error("interrupt fell without clear");
   c_rx_off: cover property ($fell(RX_ON));
   c_refused: cover property (PSLVERR);
   c_irq: cover property ($rose(IRQ));
endmodule
bind rmw_top rmw_top_asserts u_chk (.CORE_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
   .PRDATA, .PREADY, .PSLVERR, .FRAME_OK, .RX_ERROR, .RX_ON, .LONG_SFD, .RATE_FROM_HEADER, .IRQ);

/* File: test/rmw_top_tb.sv */
/* self-checking bench for the receive mode and wait timeout block.
 assumes rmw_top with its apb slave and pulse pins. */
`timescale 1ns/1ps
module rmw_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fok = 1'b0, rerr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, err, rx_on, long_sfd, rfh, irq;
   int n_mismatch = 0, num_checks = 0, seed = 32'hF2E6, m_cfg, i;
   localparam int P = 10;
   logic [31:0] mdl[logic [11:0]]; // model of the plain read-write registers
   always #2.5 clk = ~clk;
   rmw_top uut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FRAME_OK(fok),
      .RX_ERROR(rerr), .RX_ON(rx_on), .LONG_SFD(long_sfd), .RATE_FROM_HEADER(rfh), .IRQ(irq));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bits that a register keeps from a write
   function automatic logic [31:0] keep(input logic [11:0] a);
      if (a == 12'h004) return 32'hF047FFFF; // reserved cfg bits stay zero
      else if (a == 12'h00C) return 32'h0000FFFF;
      else return 32'h00000007;
   endfunction
   // one apb transfer, read data and error taken at the ready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (w && mdl.exists(a)) begin
         mdl[a] = d & keep(a);
      end else if (!w && mdl.exists(a)) begin
         chk(rd, mdl[a]);
      end
   endtask
   task pulse(input logic frame);
      if (frame) fok <= 1'b1;
      else rerr <= 1'b1;
      cyc(3);
      fok <= 1'b0;
      rerr <= 1'b0;
      cyc(6);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      cyc(5000);
      n_mismatch++;
      end_sim;
   end
   // main sequence
   initial begin
      mdl[12'h004] = 32'h00000000;
      mdl[12'h00C] = 32'h00000000;
      mdl[12'h040] = 32'h00000000;
      cyc(8);
      rst_n <= 1'b1;
      cyc(4);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      chk(rfh, 1'b1);
      for (i = 0; i < 6; i++) begin
         m_cfg = ($random(seed) & 32'h0007FFFF) | ((i % 2) << 22);
         apb(1'b1, 12'h004, m_cfg);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, m_cfg);
         cyc(2);
         chk(long_sfd, m_cfg[22]);
         chk(rfh, !m_cfg[22]);
      end
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 12'h00C, P);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, P);
      apb(1'b1, 12'h040, 32'h0);
      apb(1'b1, 12'h004, 32'h10000000);
      apb(1'b1, 12'h034, 32'h1);
      cyc(P - 3);
      chk(rx_on, 1'b1);
      cyc(6);
      chk(rx_on, 1'b0);
      apb(1'b0, 12'h03C, 32'h0);
      chk(rd, 32'h2);
      chk(irq, 1'b0);
      apb(1'b1, 12'h040, 32'h2);
      cyc(2);
      chk(irq, 1'b1);
      apb(1'b1, 12'h03C, 32'h2);
      cyc(2);
      chk(irq, 1'b0);
      // valid frame before expiry stops the count quietly
      apb(1'b1, 12'h034, 32'h1);
      cyc(2);
      pulse(1'b1);
      chk(rx_on, 1'b0);
      cyc(P);
      apb(1'b0, 12'h03C, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 12'h03C, 32'h7);
      apb(1'b1, 12'h034, 32'h1);
      apb(1'b1, 12'h034, 32'h2);
      cyc(P + 4);
      apb(1'b0, 12'h03C, 32'h0);
      chk(rd, 32'h0);
      // reception error with and without auto re-enable, no timeout
      for (i = 0; i < 2; i++) begin
         apb(1'b1, 12'h004, i << 29);
         apb(1'b1, 12'h034, 32'h1);
         pulse(1'b0);
         cyc(P);
         chk(rx_on, i);
         apb(1'b0, 12'h03C, 32'h0);
         chk(rd, 32'h4);
         apb(1'b1, 12'h03C, 32'h7);
         apb(1'b1, 12'h034, 32'h2);
      end
      end_sim;
   end
endmodule
